// ### hdl/bulk_port_control.sv
`timescale 1ns/1ps
`default_nettype none
module bulk_port_control (
   input wire logic I_CLK, // 200 MHz clock
   input wire logic I_RESET, // Async power-up reset, active high
   input wire logic I_BUS_RESET, // 1394 bus reset pulse
   input wire logic [7:0] I_ADDR, // Register byte address
   input wire logic [31:0] I_WDATA, // Write data
   input wire logic I_WR, // Write strobe
   input wire logic I_RD, // Read strobe
   output logic [31:0] O_RDATA, // Read data, cycle after strobe
   input wire bulk_port_pkg::hs_out_type I_HS, // Internal handshake levels
   output bulk_port_pkg::hs_out_type O_HS_PIN, // Handshake pins after polarity
   input wire bulk_port_pkg::hs_in_type I_HS_PIN, // Strobe pins, raw
   output bulk_port_pkg::hs_in_type O_HS, // Strobes, active high
   input wire logic [15:0] I_DATA_OUT, // Outgoing data word
   input wire logic I_REQ, // Internal request level
   output logic O_REQ_PIN, // Request pin, never floated
   output logic [15:0] O_DATA_PIN, // Data pin value
   output logic [15:0] O_DATA_OE, // Data pin drive enables
   output bulk_port_pkg::port_cfg_type O_CFG, // Decoded configuration
   output logic O_OUT_LOGIC_RESET, // Output port logic reset pulse
   output logic O_IN_LOGIC_RESET // Input port logic reset pulse
);
   import bulk_port_pkg::*;

   logic [31:0] ctrl_q;
   logic [31:0] ctrl_d;
   logic hit;
   logic [1:0] strobe_s1_q;
   logic [1:0] strobe_s2_q;
   logic [1:0] strobe_pol;
   logic [3:0] out_pol;
   logic [3:0] out_lvl;
   logic [3:0] out_pins;

   assign hit = (I_ADDR == CTRL_OFFSET);

   // ----------------------------------------
   // Control register
   // ----------------------------------------
   // Reset bits self-clear one cycle after a write sets them
   always_comb begin
      ctrl_d = ctrl_q;
      ctrl_d[POS_ORST] = 1'b0; // [R17]
      ctrl_d[POS_IRST] = 1'b0; // [R18]
      if (I_WR && hit) begin
         ctrl_d = I_WDATA & CTRL_WMASK; // [R23]
      end
      // Bus reset only touches the two self-clearing bits
      if (I_BUS_RESET) begin
         ctrl_d[POS_ORST] = 1'b0; // [R21]
         ctrl_d[POS_IRST] = 1'b0;
      end
   end

   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         ctrl_q <= CTRL_RESET; // [R21]
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   // Unmapped addresses read zero
   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         O_RDATA <= '0;
      end else if (I_RD && hit) begin
         O_RDATA <= ctrl_q;
      end else begin
         O_RDATA <= '0;
      end
   end

   // ----------------------------------------
   // Port resets
   // ----------------------------------------
   // Pulse lasts the one cycle the bit reads as set
   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         O_OUT_LOGIC_RESET <= 1'b0;
         O_IN_LOGIC_RESET <= 1'b0;
      end else begin
         O_OUT_LOGIC_RESET <= ctrl_d[POS_ORST]; // [R17]
         O_IN_LOGIC_RESET <= ctrl_d[POS_IRST]; // [R18]
      end
   end

   // ----------------------------------------
   // Decoded configuration
   // ----------------------------------------
   // Sizes are twice the code, in quadlets
   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         O_CFG <= '0;
      end else begin
         O_CFG.rx_status_buf_size <= {ctrl_d[POS_RX_BUF +: 3], 1'b0}; // [R1]
         O_CFG.tx_status_buf_size <= {ctrl_d[POS_TX_BUF +: 3], 1'b0}; // [R2]
         O_CFG.little_endian_sel <= ctrl_d[POS_LE]; // [R10]
         O_CFG.zero_fill_enable <= ctrl_d[POS_ZFILL]; // [R11]
         O_CFG.in_delay_field <= ctrl_d[POS_DELAY +: 4];
         O_CFG.out_port_protocol <= ctrl_d[POS_OPROT +: 2]; // [R13]
         O_CFG.burst_enable <= ctrl_d[POS_BURST]; // [R14]
         O_CFG.in_port_protocol <= ctrl_d[POS_IPROT +: 3]; // [R15]
         O_CFG.rx_pad_allow <= ctrl_d[POS_RXPAD]; // [R16]
         O_CFG.out_byte_hiz <= ctrl_d[POS_HIZ]; // [R20]
      end
   end

   // ----------------------------------------
   // Handshake pin polarity
   // ----------------------------------------
   assign out_pol = {ctrl_q[POS_ACK_POL], ctrl_q[POS_ASYNC_TX_ACK_PIN_POL], // [R4] [R5]
                     ctrl_q[POS_BUSY_POL], ctrl_q[POS_AVAIL_POL]}; // [R6] [R7]
   assign out_lvl = {I_HS.bulk_ack, I_HS.async_tx_ack, I_HS.in_busy, I_HS.out_avail};

   pin_polarity #(.WIDTH(4)) u_out_pol (
      .i_clk(I_CLK),
      .i_reset(I_RESET),
      .i_level(out_lvl),
      .i_high(out_pol), // [R24]
      .o_pin(out_pins)
   );

   assign O_HS_PIN.bulk_ack = out_pins[3];
   assign O_HS_PIN.async_tx_ack = out_pins[2];
   assign O_HS_PIN.in_busy = out_pins[1];
   assign O_HS_PIN.out_avail = out_pins[0];

   // Strobe pins come from outside, so synchronise first
   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         strobe_s1_q <= '0;
         strobe_s2_q <= '0;
      end else begin
         strobe_s1_q <= {I_HS_PIN.out_strobe, I_HS_PIN.in_strobe};
         strobe_s2_q <= strobe_s1_q;
      end
   end

   assign strobe_pol = {ctrl_q[POS_OSTB_POL], ctrl_q[POS_ISTB_POL]};

   // Inverted when low-active so logic sees active high
   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         O_HS <= '0;
      end else begin
         O_HS.out_strobe <= strobe_pol[1] ? strobe_s2_q[1] : ~strobe_s2_q[1]; // [R8] [R24]
         O_HS.in_strobe <= strobe_pol[0] ? strobe_s2_q[0] : ~strobe_s2_q[0]; // [R9]
      end
   end

   // ----------------------------------------
   // Data bus and request
   // ----------------------------------------
   // Upper byte enable dropped when floated; request keeps driving
   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         O_DATA_PIN <= '0;
         O_DATA_OE <= '0;
         O_REQ_PIN <= 1'b0;
      end else begin
         O_DATA_PIN <= I_DATA_OUT;
         O_DATA_OE <= {{8{~ctrl_q[POS_HIZ]}}, 8'hff}; // [R20]
         O_REQ_PIN <= I_REQ; // [R20]
      end
   end

endmodule : bulk_port_control
`default_nettype wire

// ### hdl/bulk_port_pkg.sv
// What this block does
// R1: Receive status buffer size, bits 3-5, default 101b
// R2: Transmit status buffer size, bits 6-8, default 101b
// R3: Software keeps RAM partition sum at 126 quadlets
// R4: Bit 9 sets acknowledge pin polarity
// R5: Bit 11 sets async transmit acknowledge polarity
// R6: Bit 12 sets input busy pin polarity
// R7: Bit 13 sets output available pin polarity
// R8: Bit 14 sets output strobe pin polarity
// R9: Bit 15 sets input strobe pin polarity
// R10: Bit 16 selects little endian byte order
// R11: Bit 17 zero pads, else realigns data
// R12: Software writes zeros to input delay field
// R13: Output protocol bits 22-23, default 01b
// R14: Bit 24 selects burst transfers
// R15: Input protocol bits 25-27, default 010b
// R16: Bit 28 allows receive padding, zeros kept
// R17: Bit 29 resets output logic, self clears
// R18: Bit 30 resets input logic, self clears
// R19: Software issues both port resets after changes
// R20: Bit 31 floats upper data byte only
// R21: Powers up 16800121h; bus reset keeps fields
// R22: Software sets output reset after fifo clear
// R23: Bit 0 is the register's most significant bit
// R24: Polarity applied at pins; inside always active high; reset holds handshake output pins low whatever the polarity
package bulk_port_pkg;

   localparam logic [7:0] CTRL_OFFSET = 8'h94;
   localparam logic [31:0] CTRL_RESET = 32'h16800121;

   // Bit 0 is the most significant bit, so bit n sits at index 31-n
   localparam int POS_RX_BUF = 26; // bits 3-5 -> [28:26]
   localparam int POS_TX_BUF = 23; // bits 6-8 -> [25:23]
   localparam int POS_ACK_POL = 22; // bit 9
   localparam int POS_ASYNC_TX_ACK_PIN_POL = 20; // bit 11
   localparam int POS_BUSY_POL = 19; // bit 12
   localparam int POS_AVAIL_POL = 18; // bit 13
   localparam int POS_OSTB_POL = 17; // bit 14
   localparam int POS_ISTB_POL = 16; // bit 15
   localparam int POS_LE = 15; // bit 16
   localparam int POS_ZFILL = 14; // bit 17
   localparam int POS_DELAY = 10; // bits 18-21 -> [13:10]
   localparam int POS_OPROT = 8; // bits 22-23 -> [9:8]
   localparam int POS_BURST = 7; // bit 24
   localparam int POS_IPROT = 4; // bits 25-27 -> [6:4]
   localparam int POS_RXPAD = 3; // bit 28
   localparam int POS_ORST = 2; // bit 29
   localparam int POS_IRST = 1; // bit 30
   localparam int POS_HIZ = 0; // bit 31

   // Writable bits; reserved bits 0-2 and 10 read as zero
   localparam logic [31:0] CTRL_WMASK = 32'h1fdfffff;

   // Decoded configuration handed to the port logic
   typedef struct packed {
      logic [3:0] rx_status_buf_size; // quadlets
      logic [3:0] tx_status_buf_size; // quadlets
      logic little_endian_sel;
      logic zero_fill_enable;
      logic [3:0] in_delay_field;
      logic [1:0] out_port_protocol;
      logic burst_enable;
      logic [2:0] in_port_protocol;
      logic rx_pad_allow;
      logic out_byte_hiz;
   } port_cfg_type;

   // Active-high handshake signals on the logic side
   typedef struct packed {
      logic bulk_ack;
      logic async_tx_ack;
      logic in_busy;
      logic out_avail;
   } hs_out_type;

   typedef struct packed {
      logic out_strobe;
      logic in_strobe;
   } hs_in_type;

endpackage : bulk_port_pkg

// ### hdl/pin_polarity.sv
`timescale 1ns/1ps
`default_nettype none
module pin_polarity #(
   parameter int WIDTH = 1
) (
   input wire logic i_clk, // Clock
   input wire logic i_reset, // Async reset
   input wire logic [WIDTH-1:0] i_level, // Active-high level
   input wire logic [WIDTH-1:0] i_high, // 1 means pin active high
   output logic [WIDTH-1:0] o_pin // Registered pin level
);
   // ----------------------------------------
   // Per-bit polarity flop
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         // Reset drives the pin low, whatever polarity is chosen
         always_ff @(posedge i_clk or posedge i_reset) begin
            if (i_reset) begin
               o_pin[g] <= 1'b0;
            end else begin
               o_pin[g] <= i_high[g] ? i_level[g] : ~i_level[g];
            end
         end
      end
   endgenerate
endmodule : pin_polarity
`default_nettype wire

// ### sim/bulk_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Control register checker
// ------------------------------
module bulk_ctrl_checker (
   input wire logic I_CLK, // Clock
   input wire logic I_RESET, // Reset
   input wire logic I_BUS_RESET, // Bus reset
   input wire logic [7:0] I_ADDR, // Address
   input wire logic [31:0] I_WDATA, // Write data
   input wire logic I_WR, // Write
   input wire logic I_RD, // Read
   input wire logic [31:0] O_RDATA, // Read data
   input wire bulk_port_pkg::hs_out_type I_HS, // Levels
   input wire bulk_port_pkg::hs_out_type O_HS_PIN, // Pins
   input wire bulk_port_pkg::hs_in_type I_HS_PIN, // Raw strobes
   input wire bulk_port_pkg::hs_in_type O_HS, // Strobes
   input wire logic I_REQ, // Request
   input wire logic O_REQ_PIN, // Request pin
   input wire logic [15:0] O_DATA_OE, // Enables
   input wire bulk_port_pkg::port_cfg_type O_CFG, // Config
   input wire logic O_OUT_LOGIC_RESET, // Out reset
   input wire logic O_IN_LOGIC_RESET // In reset
);
   import bulk_port_pkg::*;
   logic [31:0] s_q;
   logic [2:0] quiet_q;
   logic wr_hit;
   assign wr_hit = I_WR && I_ADDR == CTRL_OFFSET;
   // Shadow drops the self-clearing bits; pins lag writes, so count quiet cycles
   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         s_q <= CTRL_RESET;
         quiet_q <= 3'h0;
      end else begin
         if (wr_hit) s_q <= I_WDATA & CTRL_WMASK & ~32'h6;
         quiet_q <= wr_hit ? 3'h0 : quiet_q + {2'h0, quiet_q != 3'h7};
      end
   end
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RESET);
   a_read_value:
      assert property (I_RD && I_ADDR == CTRL_OFFSET |=> (O_RDATA & ~32'h6) == $past(s_q))
      else $error("read data wrong");
   a_idle_zero:
      assert property (!(I_RD && I_ADDR == CTRL_OFFSET) |=> O_RDATA == 32'h0)
      else $error("idle read data not zero");
   a_cfg_fields:
      assert property (!$past(I_RESET) |->
         O_CFG == {s_q[28:26], 1'b0, s_q[25:23], 1'b0, s_q[15:7], s_q[6:3], s_q[0]})
      else $error("decoded config wrong");
   a_ack_pins:
      assert property (quiet_q >= 3'h2 |-> O_HS_PIN == ($past(I_HS) ~^ {s_q[22], s_q[20:18]}))
      else $error("handshake pin polarity wrong");
   a_strobe_pins:
      assert property (quiet_q >= 3'h4 |-> O_HS == ($past(I_HS_PIN, 3) ~^ s_q[17:16]))
      else $error("strobe polarity wrong");
   a_oe_hiz:
      assert property (quiet_q >= 3'h2 |-> O_DATA_OE == {{8{~s_q[0]}}, 8'hff})
      else $error("data enables wrong");
   a_req_kept:
      assert property (O_REQ_PIN == $past(I_REQ))
      else $error("request pin wrong");
   a_out_pulse:
      assert property (wr_hit && I_WDATA[2] && !I_BUS_RESET |=> O_OUT_LOGIC_RESET)
      else $error("output reset pulse missing");
   a_in_cause:
      assert property (O_IN_LOGIC_RESET |-> $past(wr_hit) && $past(I_WDATA[1]))
      else $error("input reset pulse without write");
endmodule : bulk_ctrl_checker
`default_nettype wire

// ### sim/dma_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Host DMA strobe driver
// ------------------------------
module dma_host_model (
   input wire logic i_clk, // Clock
   input wire bulk_port_pkg::hs_in_type i_want, // Strobes, active high
   input wire logic [1:0] i_pol, // 1 means pin active high
   output bulk_port_pkg::hs_in_type o_pin // Raw strobe pins
);
   import bulk_port_pkg::*;
   // Pins move only after an edge, like a real host
   always_ff @(posedge i_clk) begin
      o_pin <= i_want ~^ i_pol;
   end
endmodule : dma_host_model
`default_nettype wire

// ### sim/test_bulk_port_control.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Control register bench
// ------------------------------
module test_bulk_port_control;
   import bulk_port_pkg::*;
   logic I_CLK = 1'b0;
   logic I_RESET = 1'b1;
   logic I_BUS_RESET = 1'b0;
   logic I_WR = 1'b0;
   logic I_RD = 1'b0;
   logic I_REQ = 1'b0;
   logic [7:0] I_ADDR = 8'h0;
   logic [31:0] I_WDATA = 32'h0;
   logic [15:0] I_DATA_OUT = 16'h5a3c;
   hs_out_type I_HS = 4'h0;
   hs_in_type want = 2'h0;
   logic [1:0] pol = 2'h0;
   hs_out_type O_HS_PIN;
   hs_in_type I_HS_PIN, O_HS;
   port_cfg_type O_CFG;
   logic [31:0] O_RDATA, w;
   logic [15:0] O_DATA_PIN, O_DATA_OE;
   logic O_REQ_PIN, O_OUT_LOGIC_RESET, O_IN_LOGIC_RESET;
   int n_fail = 0;
   int n_checks = 0;
   // 200 MHz clock
   always #2.5 I_CLK = ~I_CLK;
   bulk_port_control bulk_port_control_i (.I_CLK, .I_RESET, .I_BUS_RESET, .I_ADDR, .I_WDATA,
      .I_WR, .I_RD, .O_RDATA, .I_HS, .O_HS_PIN, .I_HS_PIN, .O_HS, .I_DATA_OUT, .I_REQ,
      .O_REQ_PIN, .O_DATA_PIN, .O_DATA_OE, .O_CFG, .O_OUT_LOGIC_RESET, .O_IN_LOGIC_RESET);
   dma_host_model dma_host_model_i (.i_clk(I_CLK), .i_want(want), .i_pol(pol), .o_pin(I_HS_PIN));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Bus cycles end just after the taking edge, so results have landed
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge I_CLK);
      I_ADDR <= a;
      I_WDATA <= d;
      I_WR <= 1'b1;
      @(posedge I_CLK);
      I_WR <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge I_CLK);
      I_ADDR <= a;
      I_RD <= 1'b1;
      @(posedge I_CLK);
      I_RD <= 1'b0;
      #1;
      chk(O_RDATA, exp);
   endtask : rd
   function automatic port_cfg_type cfg_of(input logic [31:0] s);
      return {s[28:26], 1'b0, s[25:23], 1'b0, s[15:7], s[6:3], s[0]};
   endfunction : cfg_of
   task automatic complete_run;
      $display("checks=%0d failures=%0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : complete_run
   // Main sequence
   initial begin
      repeat (6) @(posedge I_CLK);
      I_RESET <= 1'b0;
      rd(CTRL_OFFSET, CTRL_RESET);
      chk({10'h0, O_CFG}, {10'h0, cfg_of(CTRL_RESET)});
      chk({16'h0, O_DATA_OE}, 32'h00ff);
      wr(8'h98, 32'h0);
      rd(8'h98, 32'h0);
      rd(CTRL_OFFSET, CTRL_RESET);
      w = 32'hfe7fc3f9; // Reserved bits set, delay field zero
      wr(CTRL_OFFSET, w);
      rd(CTRL_OFFSET, w & CTRL_WMASK);
      for (int i = 0; i < 8; i++) begin
         w = (i << 26) | ((7 - i) << 23) | ((i & 3) << 8) | (i << 4);
         w = w | (i[0] ? 32'hc088 : 32'h0); // Sizes stay within the shared RAM
         wr(CTRL_OFFSET, w);
         chk({10'h0, O_CFG}, {10'h0, cfg_of(w)});
      end
      for (int p = 0; p < 2; p++) begin
         @(posedge I_CLK);
         pol <= p ? 2'h3 : 2'h0;
         want <= 2'b10;
         I_HS <= 4'b1010;
         I_REQ <= p[0];
         wr(CTRL_OFFSET, (p ? 32'h005f0000 : 32'h0) | 32'h6);
         chk({30'h0, O_OUT_LOGIC_RESET, O_IN_LOGIC_RESET}, 32'h3);
         repeat (4) @(posedge I_CLK);
         #1;
         chk({30'h0, O_OUT_LOGIC_RESET, O_IN_LOGIC_RESET}, 32'h0);
         chk({28'h0, O_HS_PIN}, p ? 32'ha : 32'h5);
         chk({30'h0, O_HS}, 32'h2);
         chk({31'h0, O_REQ_PIN}, p);
         chk({16'h0, O_DATA_OE}, 32'hffff);
         rd(CTRL_OFFSET, p ? 32'h005f0000 : 32'h0);
      end
      @(posedge I_CLK);
      I_BUS_RESET <= 1'b1;
      @(posedge I_CLK);
      I_BUS_RESET <= 1'b0;
      rd(CTRL_OFFSET, 32'h005f0000);
      // Bus reset beside a write of the reset bits: the clear wins
      @(posedge I_CLK);
      I_BUS_RESET <= 1'b1;
      I_ADDR <= CTRL_OFFSET;
      I_WDATA <= 32'h6;
      I_WR <= 1'b1;
      @(posedge I_CLK);
      I_BUS_RESET <= 1'b0;
      I_WR <= 1'b0;
      #1;
      chk({30'h0, O_OUT_LOGIC_RESET, O_IN_LOGIC_RESET}, 32'h0);
      rd(CTRL_OFFSET, 32'h0);
      complete_run();
   end
   // Cut a hang short; the tests need well under 300 cycles
   initial begin
      repeat (2000) @(posedge I_CLK);
      n_fail++;
      complete_run();
   end
endmodule : test_bulk_port_control
bind bulk_port_control bulk_ctrl_checker bulk_ctrl_checker_i (.I_CLK, .I_RESET, .I_BUS_RESET,
   .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA, .I_HS, .O_HS_PIN, .I_HS_PIN, .O_HS, .I_REQ,
   .O_REQ_PIN, .O_DATA_OE, .O_CFG, .O_OUT_LOGIC_RESET, .O_IN_LOGIC_RESET);
`default_nettype wire
